// [design/rtci_master.sv]
// Functional notes
// - Lines only pulled low or released.
// - SDA falls while SCL high: start.
// - SDA rises while SCL high: stop.
// - Master alone makes start, restart, stop.
// - Transaction must finish within 0.95 seconds.
// - After timeout master issues fresh start.
// - At least 1.3 us between stop, start.
// - Eight-bit units, unlimited byte count.
// - SDA changes only while SCL low.
// - Receiver pulls SDA low for acknowledge.
// - Acknowledge released at ninth falling SCL.
// - Master withholds acknowledge after last read.
// - Bit 0 of address byte selects direction.
// - First written byte loads register pointer.
// - Pointer-set read uses write, restart, read.
`timescale 1ns/1ps
`default_nettype none

module rtci_master #(
	parameter int QTR_CYC = rtci_pkg::RTCI_QTR_CYC,
	parameter int TOUT_CYC = rtci_pkg::RTCI_TOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic rsp_err,
	output logic busy,
	output logic tout_flag,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	rtci_pkg::rtci_state_e state_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic ack_reg;
	logic rd_op_reg;
	logic dir_rd_reg;
	logic addr_next_reg;
	logic in_txn_reg;
	logic tout_reg;
	logic line_lo_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic cmd_ready_reg;
	logic rsp_valid_reg;
	logic [7:0] rsp_data_reg;
	logic rsp_nack_reg;
	logic rsp_err_reg;
	logic [15:0] qcnt_reg;
	logic [rtci_pkg::RTCI_BUF_W-1:0] buf_reg;
	logic [rtci_pkg::RTCI_TMR_W-1:0] tmr_reg;
	logic scl_s;
	logic sda_s;
	logic take;
	logic q_done;
	logic adv;
	logic start_go;

	rtci_sync u_scl_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.line_in(scl_i),
		.line_out(scl_s)
	);

	rtci_sync u_sda_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.line_in(sda_i),
		.line_out(sda_s)
	);

	assign take = cmd_valid && cmd_ready_reg;
	assign start_go = take && (cmd_op == rtci_pkg::RTCI_OP_START);
	assign q_done = (qcnt_reg == 16'(QTR_CYC - 1));
	// A released SCL may be held low by the target; wait until it is high.
	assign adv = q_done && ((phase_reg != 2'h1) || scl_s);

	assign scl_o = line_lo_reg;
	assign sda_o = line_lo_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign cmd_ready = cmd_ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;
	assign rsp_nack = rsp_nack_reg;
	assign rsp_err = rsp_err_reg;
	assign busy = in_txn_reg;
	assign tout_flag = tout_reg;

	always_ff @(posedge sys_clk) begin
		line_lo_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || adv) begin
			qcnt_reg <= 16'h0000;
		end else if (q_done) begin
			// Hold at the end of the quarter while a stretched SCL stays low.
			qcnt_reg <= qcnt_reg;
		end else if (state_reg == rtci_pkg::RTCI_ST_START ||
			state_reg == rtci_pkg::RTCI_ST_BIT ||
			state_reg == rtci_pkg::RTCI_ST_STOP) begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end else begin
			qcnt_reg <= 16'h0000;
		end
	end

	// Transaction timer; a timeout set in the same cycle as a start wins.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tmr_reg <= '0;
			tout_reg <= 1'b0;
		end else begin
			if (start_go || !in_txn_reg) begin
				tmr_reg <= '0;
			end else if (!tout_reg) begin
				tmr_reg <= tmr_reg + rtci_pkg::RTCI_TMR_W'(1);
			end
			if (start_go) begin
				tout_reg <= 1'b0;
			end
			if (in_txn_reg &&
				tmr_reg == rtci_pkg::RTCI_TMR_W'(TOUT_CYC - 1)) begin
				tout_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= rtci_pkg::RTCI_ST_IDLE;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			ack_reg <= 1'b0;
			rd_op_reg <= 1'b0;
			dir_rd_reg <= 1'b0;
			addr_next_reg <= 1'b0;
			in_txn_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			cmd_ready_reg <= 1'b1;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 8'h00;
			rsp_nack_reg <= 1'b0;
			rsp_err_reg <= 1'b0;
			buf_reg <= '0;
		end else begin
			rsp_valid_reg <= 1'b0;
			case (state_reg)
			rtci_pkg::RTCI_ST_IDLE, rtci_pkg::RTCI_ST_HOLD: begin
				if (take) begin
					rsp_err_reg <= 1'b0;
					rsp_nack_reg <= 1'b0;
					if (cmd_op == rtci_pkg::RTCI_OP_START) begin
						// Start and restart share one line sequence.
						state_reg <= rtci_pkg::RTCI_ST_START;
						phase_reg <= 2'h0;
						sda_oe_reg <= 1'b0;
						cmd_ready_reg <= 1'b0;
						addr_next_reg <= 1'b1;
					end else if (state_reg == rtci_pkg::RTCI_ST_IDLE ||
						(cmd_op != rtci_pkg::RTCI_OP_STOP && tout_reg) ||
						(cmd_op == rtci_pkg::RTCI_OP_WRITE &&
						dir_rd_reg && !addr_next_reg) ||
						(cmd_op == rtci_pkg::RTCI_OP_READ &&
						(addr_next_reg || !dir_rd_reg))) begin
						// Refused: no bus activity, error answer next cycle.
						rsp_valid_reg <= 1'b1;
						rsp_err_reg <= 1'b1;
					end else if (cmd_op == rtci_pkg::RTCI_OP_STOP) begin
						state_reg <= rtci_pkg::RTCI_ST_STOP;
						phase_reg <= 2'h0;
						sda_oe_reg <= 1'b1;
						cmd_ready_reg <= 1'b0;
					end else begin
						state_reg <= rtci_pkg::RTCI_ST_BIT;
						phase_reg <= 2'h0;
						bit_reg <= 4'h0;
						cmd_ready_reg <= 1'b0;
						rd_op_reg <= (cmd_op == rtci_pkg::RTCI_OP_READ);
						ack_reg <= cmd_ack;
						if (cmd_op == rtci_pkg::RTCI_OP_READ) begin
							shift_reg <= 8'hFF;
							sda_oe_reg <= 1'b0;
						end else begin
							shift_reg <= cmd_data;
							sda_oe_reg <= ~cmd_data[7];
						end
						if (cmd_op == rtci_pkg::RTCI_OP_WRITE &&
							addr_next_reg) begin
							// This is the address byte; latch its direction bit.
							dir_rd_reg <=
								cmd_data[rtci_pkg::RTCI_DIR_BIT];
							addr_next_reg <= 1'b0;
						end
					end
				end
			end
			rtci_pkg::RTCI_ST_START: begin
				if (adv) begin
					phase_reg <= phase_reg + 2'h1;
					case (phase_reg)
					2'h0: begin
						scl_oe_reg <= 1'b0;
					end
					2'h1: begin
						sda_oe_reg <= 1'b1;
					end
					2'h2: begin
						scl_oe_reg <= 1'b1;
					end
					default: begin
						state_reg <= rtci_pkg::RTCI_ST_HOLD;
						in_txn_reg <= 1'b1;
						cmd_ready_reg <= 1'b1;
						rsp_valid_reg <= 1'b1;
					end
					endcase
				end
			end
			rtci_pkg::RTCI_ST_BIT: begin
				if (adv) begin
					phase_reg <= phase_reg + 2'h1;
					case (phase_reg)
					2'h0: begin
						scl_oe_reg <= 1'b0;
					end
					2'h1: begin
						if (bit_reg == rtci_pkg::RTCI_BIT_ACK) begin
							rsp_nack_reg <= sda_s;
						end else begin
							shift_reg <= {shift_reg[6:0], sda_s};
						end
					end
					2'h2: begin
						scl_oe_reg <= 1'b1;
					end
					default: begin
						if (bit_reg == rtci_pkg::RTCI_BIT_ACK) begin
							// Whoever drove the acknowledge lets go now.
							state_reg <= rtci_pkg::RTCI_ST_HOLD;
							sda_oe_reg <= 1'b0;
							cmd_ready_reg <= 1'b1;
							rsp_valid_reg <= 1'b1;
							rsp_data_reg <= shift_reg;
						end else if (bit_reg ==
							rtci_pkg::RTCI_BIT_LAST_DATA) begin
							bit_reg <= bit_reg + 4'h1;
							// Ack slot: host acks reads when cmd_ack is set, releases on writes.
							sda_oe_reg <= rd_op_reg && ack_reg;
						end else begin
							bit_reg <= bit_reg + 4'h1;
							sda_oe_reg <= !rd_op_reg && !shift_reg[7];
						end
					end
					endcase
				end
			end
			rtci_pkg::RTCI_ST_STOP: begin
				if (adv) begin
					phase_reg <= phase_reg + 2'h1;
					if (phase_reg == 2'h0) begin
						scl_oe_reg <= 1'b0;
					end else if (phase_reg == 2'h1) begin
						sda_oe_reg <= 1'b0;
					end else begin
						state_reg <= rtci_pkg::RTCI_ST_BUF;
						in_txn_reg <= 1'b0;
						buf_reg <= '0;
					end
				end
			end
			rtci_pkg::RTCI_ST_BUF: begin
				if (buf_reg ==
					rtci_pkg::RTCI_BUF_W'(rtci_pkg::RTCI_TBUF_CYC - 1)) begin
					state_reg <= rtci_pkg::RTCI_ST_IDLE;
					cmd_ready_reg <= 1'b1;
					rsp_valid_reg <= 1'b1;
				end else begin
					buf_reg <= buf_reg + rtci_pkg::RTCI_BUF_W'(1);
				end
			end
			default: begin
				state_reg <= rtci_pkg::RTCI_ST_IDLE;
			end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence start_hold_s;
		sda_oe_reg && !scl_oe_reg;
	endsequence

	open_drain_a: assert property (!line_lo_reg ##1 !line_lo_reg)
		else $error("bus lines driven to a high level");
	start_edge_a: assert property (
		$rose(sda_oe_reg) && !scl_oe_reg |->
		state_reg == rtci_pkg::RTCI_ST_START ##0 start_hold_s
		##[1:1000] scl_oe_reg)
		else $error("SDA fell with SCL high outside a start");
	stop_edge_a: assert property (
		$fell(sda_oe_reg) && !scl_oe_reg |->
		$past(state_reg) == rtci_pkg::RTCI_ST_STOP)
		else $error("SDA rose with SCL high outside a stop");
	data_stable_a: assert property (
		state_reg == rtci_pkg::RTCI_ST_BIT && $changed(sda_oe_reg) |->
		scl_oe_reg && $past(scl_oe_reg))
		else $error("data changed while SCL released");
	timeout_set_a: assert property (
		$rose(tout_reg) |->
		$past(tmr_reg) == rtci_pkg::RTCI_TMR_W'(TOUT_CYC - 1) &&
		$past(in_txn_reg))
		else $error("timeout flag not tied to the timer limit");
	refuse_after_a: assert property (
		take && tout_reg && state_reg == rtci_pkg::RTCI_ST_HOLD &&
		cmd_op != rtci_pkg::RTCI_OP_START &&
		cmd_op != rtci_pkg::RTCI_OP_STOP |=>
		rsp_valid_reg && rsp_err_reg &&
		state_reg == rtci_pkg::RTCI_ST_HOLD)
		else $error("byte transfer allowed after timeout");
	bus_free_a: assert property (
		state_reg == rtci_pkg::RTCI_ST_IDLE &&
		$past(state_reg) == rtci_pkg::RTCI_ST_BUF |->
		$past(buf_reg) ==
		rtci_pkg::RTCI_BUF_W'(rtci_pkg::RTCI_TBUF_CYC - 1))
		else $error("bus free time cut short");
	ack_drive_a: assert property (
		state_reg == rtci_pkg::RTCI_ST_BIT &&
		bit_reg == rtci_pkg::RTCI_BIT_ACK && rd_op_reg |->
		sda_oe_reg == ack_reg)
		else $error("read acknowledge level wrong");
	ack_release_a: assert property (
		state_reg == rtci_pkg::RTCI_ST_HOLD &&
		$past(state_reg) == rtci_pkg::RTCI_ST_BIT |->
		!sda_oe_reg && scl_oe_reg)
		else $error("SDA not released after the ninth clock");
	byte_len_a: assert property (
		rsp_valid_reg && $past(state_reg) == rtci_pkg::RTCI_ST_BIT |->
		$past(bit_reg) == rtci_pkg::RTCI_BIT_ACK)
		else $error("byte finished after a wrong bit count");

endmodule : rtci_master

`default_nettype wire

// [design/rtci_pkg.sv]
`default_nettype none

package rtci_pkg;

	// Target address 7'b1010001 followed by the direction bit.
	localparam logic [6:0] RTCI_DEV_ADDR = 7'h51;
	localparam logic [7:0] RTCI_ADDR_WR = 8'hA2;
	localparam logic [7:0] RTCI_ADDR_RD = 8'hA3;
	localparam int RTCI_DIR_BIT = 0;

	localparam int RTCI_CLK_NS = 5;
	localparam int RTCI_TBUF_NS = 1300;
	localparam int RTCI_TBUF_CYC =
		(RTCI_TBUF_NS + RTCI_CLK_NS - 1) / RTCI_CLK_NS;
	localparam int RTCI_TOUT_MS = 950;
	localparam int RTCI_TOUT_CYC =
		(RTCI_TOUT_MS * 1000000) / RTCI_CLK_NS;
	localparam int RTCI_QTR_CYC = 500;
	localparam int RTCI_TMR_W = 28;
	localparam int RTCI_BUF_W = 9;

	localparam logic [3:0] RTCI_BIT_ACK = 4'h8;
	localparam logic [3:0] RTCI_BIT_LAST_DATA = 4'h7;
	localparam logic RTCI_LINE_IDLE = 1'b1;

	typedef enum logic [1:0] {
		RTCI_OP_START,
		RTCI_OP_WRITE,
		RTCI_OP_READ,
		RTCI_OP_STOP
	} rtci_op_e;

	typedef enum logic [2:0] {
		RTCI_ST_IDLE,
		RTCI_ST_START,
		RTCI_ST_HOLD,
		RTCI_ST_BIT,
		RTCI_ST_STOP,
		RTCI_ST_BUF
	} rtci_state_e;

endpackage : rtci_pkg

`default_nettype wire

// [design/rtci_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a bus line; resets to the released level.
module rtci_sync (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic line_in,
	output logic line_out
);

	logic meta_reg;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			meta_reg <= rtci_pkg::RTCI_LINE_IDLE;
			line_out <= rtci_pkg::RTCI_LINE_IDLE;
		end else begin
			meta_reg <= line_in;
			line_out <= meta_reg;
		end
	end

endmodule : rtci_sync

`default_nettype wire

// [testbench/rtci_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Behavioural target with sixteen registers behind a wrapping pointer.
module rtci_dev_model #(
	parameter real TOUT_NS = 10000.0
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull
);
	logic [7:0] mem [16];
	logic [7:0] sh;
	logic [3:0] ptr;
	logic act, sel, rd, mack;
	int bc, nb;
	realtime t0;
	initial begin
		t0 = 0.0;
		sda_pull = 1'b0;
		act = 1'b0;
		ptr = 4'h0;
		for (int i = 0; i < 16; i++)
			mem[i] = 8'h10 + 8'(i);
	end
	always @(negedge sda) if (scl === 1'b1) begin
		// A restart keeps the transaction timer; a timed-out one is fresh.
		if (!act || $realtime - t0 >= TOUT_NS)
			t0 = $realtime;
		act = 1'b1;
		// The falling SCL that closes the start carries no bit.
		bc = -1;
		nb = 0;
		sel = 1'b0;
		rd = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		act = 1'b0;
		sda_pull = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (bc < 8)
			sh = {sh[6:0], sda};
		else
			mack = ~sda;
	end
	always @(negedge scl) if (act && $realtime - t0 >= TOUT_NS) begin
		// Timed out: back to standby, so writes drop and reads see ones.
		act = 1'b0;
		sda_pull = 1'b0;
	end else if (act) begin
		if (bc == 7 && rd) begin
			sda_pull = 1'b0;
			ptr = ptr + 4'h1;
		end else if (bc == 7) begin
			if (nb == 0) begin
				sel = (sh[7:1] == 7'h51);
				rd = sh[0];
			end else if (sel && nb == 1)
				ptr = sh[3:0];
			else if (sel) begin
				mem[ptr] = sh;
				ptr = ptr + 4'h1;
			end
			sda_pull = sel;
		end else if (bc == 8) begin
			nb++;
			if (rd && !mack)
				sel = 1'b0;
			sda_pull = sel && rd && !mem[ptr][7];
		end else if (sel && rd)
			sda_pull = !mem[ptr][6 - bc];
		bc = (bc == 8) ? 0 : bc + 1;
	end
endmodule : rtci_dev_model

`default_nettype wire

// [testbench/rtci_master_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module rtci_master_tb_top;
	localparam int TOUT = 2000;
	localparam logic [1:0] S = rtci_pkg::RTCI_OP_START;
	localparam logic [1:0] W = rtci_pkg::RTCI_OP_WRITE;
	localparam logic [1:0] R = rtci_pkg::RTCI_OP_READ;
	localparam logic [1:0] P = rtci_pkg::RTCI_OP_STOP;
	localparam logic [11:0] EOK = 12'h000;
	localparam logic [11:0] EER = 12'h200;
	logic sys_clk, resetn, cmd_valid, cmd_ack, cmd_ready, rsp_valid;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data, d0, d1, ph;
	logic rsp_nack, rsp_err, busy, tout_flag;
	logic scl_o, scl_oe, sda_o, sda_oe, dev_pull;
	wire logic scl;
	wire logic sda;
	logic [11:0] exp_q [$];
	logic [11:0] e;
	int errors, checks;
	// Both lines have pull-ups: released reads high.
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_oe ? sda_o : 1'b1) & ~dev_pull;

	rtci_master #(.QTR_CYC(4), .TOUT_CYC(TOUT)) rtci_master_i (
		.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .rsp_err(rsp_err), .busy(busy),
		.tout_flag(tout_flag), .scl_i(scl), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
	);
	rtci_dev_model #(
		.TOUT_NS(real'(TOUT * rtci_pkg::RTCI_CLK_NS))
	) rtci_dev_model_i (
		.scl(scl), .sda(sda), .sda_pull(dev_pull)
	);

	function automatic logic [11:0] wr(input logic n, input logic [7:0] d);
		return {3'b110, n, d};
	endfunction : wr
	function automatic logic [11:0] rdx(input logic a, input logic [7:0] d);
		return {3'b110, ~a, d};
	endfunction : rdx
	task automatic cmp8(input string n, input logic [7:0] x,
		input logic [7:0] g);
		checks++;
		if (g !== x) begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : cmp8
	task automatic cmp1(input string n, input logic x, input logic g);
		checks++;
		if (g !== x) begin
			errors++;
			$display("Error %s expected %b seen %b", n, x, g);
		end
	endtask : cmp1
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic cmd(input logic [1:0] op, input logic [7:0] d,
		input logic a, input logic [11:0] x);
		exp_q.push_back(x);
		cmd_op <= op;
		cmd_data <= d;
		cmd_ack <= a;
		cmd_valid <= 1'b1;
		while (cmd_ready !== 1'b1)
			tick();
		tick();
		cmd_valid <= 1'b0;
		for (int i = 0; i < 4000 && exp_q.size() != 0; i++)
			tick();
		if (exp_q.size() != 0) begin
			cmp1("rsp_valid", 1'b1, 1'b0);
			exp_q.delete();
		end
	endtask : cmd

	always @(negedge sys_clk) if (rsp_valid === 1'b1) begin
		cmp1("rsp_expected", 1'b1, exp_q.size() != 0);
		e = exp_q.pop_front();
		cmp1("rsp_err", e[9], rsp_err);
		if (e[10])
			cmp1("rsp_nack", e[8], rsp_nack);
		if (e[11])
			cmp8("rsp_data", e[7:0], rsp_data);
	end

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		cmp1("watchdog", 1'b0, 1'b1);
		end_sim();
	end
	initial begin
		errors = 0;
		checks = 0;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		void'($urandom(51));
		ph = 8'($urandom());
		d0 = 8'($urandom());
		d1 = 8'($urandom());
		ph[3:0] = 4'hF;
		repeat (3) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		cmd(W, d0, 1'b0, EER);
		cmd(P, 8'h00, 1'b0, EER);
		cmd(S, 8'h00, 1'b0, EOK);
		cmd(W, 8'hA2, 1'b0, wr(1'b0, 8'hA2));
		cmd(W, ph, 1'b0, wr(1'b0, ph));
		cmd(W, d0, 1'b0, wr(1'b0, d0));
		cmd(W, d1, 1'b0, wr(1'b0, d1));
		cmd(R, 8'h00, 1'b1, EER);
		cmd(P, 8'h00, 1'b0, EOK);
		cmd(S, 8'h00, 1'b0, EOK);
		cmd(R, 8'h00, 1'b1, EER);
		cmd(W, 8'hA0, 1'b0, wr(1'b1, 8'hA0));
		cmd(P, 8'h00, 1'b0, EOK);
		cmd(S, 8'h00, 1'b0, EOK);
		cmd(W, 8'hA2, 1'b0, wr(1'b0, 8'hA2));
		cmd(W, ph, 1'b0, wr(1'b0, ph));
		cmd(S, 8'h00, 1'b0, EOK);
		cmd(W, 8'hA3, 1'b0, wr(1'b0, 8'hA3));
		cmd(R, 8'h00, 1'b1, rdx(1'b1, d0));
		cmd(R, 8'h00, 1'b0, rdx(1'b0, d1));
		cmd(P, 8'h00, 1'b0, EOK);
		cmd(S, 8'h00, 1'b0, EOK);
		cmd(W, 8'hA3, 1'b0, wr(1'b0, 8'hA3));
		cmd(W, d0, 1'b0, EER);
		cmd(R, 8'h00, 1'b0, rdx(1'b0, 8'h11));
		cmd(P, 8'h00, 1'b0, EOK);
		cmd(S, 8'h00, 1'b0, EOK);
		cmp1("tout_flag", 1'b0, tout_flag);
		cmp1("busy", 1'b1, busy);
		repeat (TOUT + 100) tick();
		cmp1("tout_flag", 1'b1, tout_flag);
		cmd(W, 8'hA2, 1'b0, EER);
		cmd(S, 8'h00, 1'b0, EOK);
		cmp1("tout_flag", 1'b0, tout_flag);
		cmd(P, 8'h00, 1'b0, EOK);
		cmp1("busy", 1'b0, busy);
		end_sim();
	end
endmodule : rtci_master_tb_top

`default_nettype wire
